// File: core/pms_pkg.sv
// Constants and types shared by the program memory selector
package pms_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;
  localparam int FADE_TIME_MS  = 8;
  localparam int BEEP_TIME_MS  = 100;
  localparam int POR_UNIT_MS   = 1000;
  localparam int FADE_CYC      = FADE_TIME_MS * CYC_PER_MS;
  localparam int BEEP_CYC      = BEEP_TIME_MS * CYC_PER_MS;
  localparam int POR_UNIT_CYC  = POR_UNIT_MS * CYC_PER_MS;
  localparam logic [3:0] POR_MAX_UNITS = 4'hB;
  localparam int SYNC_W        = 5;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_VALID  = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_STYLE_BIT  = 0;
  localparam int CTRL_JUMP_BIT   = 1;
  localparam int CTRL_BEEP_BIT   = 2;
  localparam int CTRL_SUPPLY_LSB = 4;
  localparam int CTRL_TONE_BIT   = 6;
  localparam int CTRL_PROG_BIT   = 7;
  localparam int CTRL_POR_LSB    = 8;

  localparam int STAT_MEM_LSB   = 0;
  localparam int STAT_MUTE_BIT  = 4;
  localparam int STAT_POR_BIT   = 5;
  localparam int STAT_FADE_BIT  = 6;
  localparam int STAT_TONE_BIT  = 7;
  localparam int STAT_SW_LSB    = 8;
  localparam int STAT_REINIT_BIT = 10;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0204;
  localparam logic [31:0] VALID_RST = 32'h0000_000F;
  localparam logic [3:0]  POR_RST_UNITS = 4'h2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MEM_A = 3'h0;
  localparam logic [2:0] MEM_B = 3'h1;
  localparam logic [2:0] MEM_C = 3'h2;
  localparam logic [2:0] MEM_D = 3'h3;

  localparam logic [1:0] SUP_SHALLOW = 2'h0;
  localparam logic [1:0] SUP_DEEP    = 2'h1;
  localparam logic [1:0] SUP_ADV     = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'b00001,
    ST_FADE_OUT = 5'b00010,
    ST_BEEP     = 5'b00100,
    ST_SWITCH   = 5'b01000,
    ST_FADE_IN  = 5'b10000
  } pms_state_t;

endpackage

// File: core/pms_selector.sv
// Program memory selector with fader sequencing and low-supply handling
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module pms_selector
  import pms_pkg::*;
#(
  parameter int FADE_CYCLES = FADE_CYC,
  parameter int BEEP_CYCLES = BEEP_CYC,
  parameter int UNIT_CYCLES = POR_UNIT_CYC,
  parameter int NUM_MEM     = 6
) (
  input  wire logic        clk,                     // System clock, 50 MHz
  input  wire logic        rst,                     // Async reset, high
  input  wire logic [3:0]  avs_address,             // Byte address
  input  wire logic        avs_read,                // Read request
  input  wire logic        avs_write,               // Write request
  input  wire logic [31:0] avs_writedata,           // Write data
  input  wire logic [3:0]  avs_byteenable,          // Byte lanes
  output logic      [31:0] avs_readdata,            // Read data
  output logic             avs_waitrequest,         // Stall request
  input  wire logic        primary_select_switch,   // Momentary/static pin
  input  wire logic        secondary_select_switch, // Static pin
  input  wire logic        supply_above_095,        // Supply over 0.95 V
  input  wire logic        supply_above_110,        // Supply over 1.1 V
  input  wire logic        supply_above_060,        // Supply over 0.6 V
  output logic      [2:0]  memory_sel,              // Active memory
  output logic             audio_enable,            // Audio path enabled
  output logic             fader_down,              // Fader commanded down
  output logic             indicator_start,         // Start select beep
  output logic             tone_enable              // Tone generator on
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] pins_w;

  assign pins_w = {supply_above_060, supply_above_110, supply_above_095,
                   secondary_select_switch, primary_select_switch};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  wire sw_p = sync2_r[0];
  wire sw_s = sync2_r[1];
  wire a095 = sync2_r[2];
  wire a110 = sync2_r[3];
  wire a060 = sync2_r[4];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  function automatic logic [31:0] pms_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [31:0] ctrl_r;
  logic [31:0] valid_r;
  logic [31:0] rdata_r;
  logic        ack_r;
  logic [31:0] status_w;
  logic [31:0] rmux_w;

  wire req_w    = avs_read | avs_write;
  wire wr_go    = avs_write & ack_r;
  wire sel_ctrl = avs_address == ADDR_CTRL;
  wire sel_vld  = avs_address == ADDR_VALID;
  wire sel_stat = avs_address == ADDR_STATUS;

  assign avs_waitrequest = req_w & ~ack_r;
  assign avs_readdata    = rdata_r;

  // Unmapped addresses read zero; writes to them are dropped
  assign rmux_w = sel_ctrl ? ctrl_r :
                  sel_vld  ? valid_r :
                  sel_stat ? status_w : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ctrl_r  <= CTRL_RST;
      valid_r <= VALID_RST;
    end else begin
      ack_r <= req_w & ~ack_r;
      if (avs_read & ~ack_r) begin
        rdata_r <= rmux_w;
      end
      if (wr_go & sel_ctrl) begin
        ctrl_r <= pms_merge(ctrl_r, avs_writedata, avs_byteenable) &
                  32'h0000_0FF7;
      end
      if (wr_go & sel_vld) begin
        valid_r <= pms_merge(valid_r, avs_writedata, avs_byteenable) &
                   32'h0000_003F;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic [NUM_MEM-1:0] valid_w;
  assign valid_w = valid_r[NUM_MEM-1:0] | {{(NUM_MEM-1){1'b0}}, 1'b1};

  wire style_static   = ctrl_r[CTRL_STYLE_BIT];
  wire jump_en        = ctrl_r[CTRL_JUMP_BIT];
  wire beep_en        = ctrl_r[CTRL_BEEP_BIT];
  wire tone_cfg       = ctrl_r[CTRL_TONE_BIT];
  wire prog_busy      = ctrl_r[CTRL_PROG_BIT];
  wire [1:0] sup_mode = ctrl_r[CTRL_SUPPLY_LSB +: 2];
  wire [3:0] por_cfg  = ctrl_r[CTRL_POR_LSB +: 4];

  wire mode_mom_jump    = ~style_static & jump_en;
  wire mode_static_dual = style_static & ~jump_en;
  wire mode_static_jump = style_static & jump_en;
  // Advanced mode is not built here; it behaves as shallow
  wire sup_deep = sup_mode == SUP_DEEP;

  // ----------------------------------------------------------------
  // Memory selection
  // ----------------------------------------------------------------
  function automatic logic [2:0] pms_next(input logic [2:0]         cur,
                                          input logic [NUM_MEM-1:0] mask,
                                          input logic               skip_d);
    logic [2:0] res;
    logic       found;
    int         idx;
    res   = MEM_A;
    found = 1'b0;
    for (int k = 1; k <= NUM_MEM; k++) begin
      idx = (int'(cur) + k) % NUM_MEM;
      if (!found && mask[idx] && !(skip_d && idx == int'(MEM_D))) begin
        found = 1'b1;
        res   = 3'(idx);
      end
    end
    return res;
  endfunction

  logic [2:0] base_r;
  logic       prim_d_r;
  logic       por_run;
  logic       reinit_go;
  logic [2:0] dual_idx;
  logic [2:0] dual_w;
  logic [2:0] sjump_w;
  logic [2:0] req_mem;
  logic [2:0] base_nxt;

  wire press_w  = sw_p & ~prim_d_r;
  // Presses are only meaningful for the momentary styles
  wire press_ok = press_w & ~style_static & ~por_run
                  & ~(mode_mom_jump & sw_s);

  assign base_nxt = pms_next(base_r, valid_w, mode_mom_jump);
  assign dual_idx = {1'b0, sw_s, sw_p};
  assign dual_w   = valid_w[dual_idx] ? dual_idx : MEM_A;
  // Primary is a don't-care whenever secondary is high
  assign sjump_w  = sw_s ? MEM_D :
                    (sw_p && valid_w[MEM_B]) ? MEM_B : MEM_A;
  assign req_mem  = mode_static_jump ? sjump_w :
                    mode_static_dual ? dual_w :
                    (mode_mom_jump & sw_s) ? MEM_D :
                    base_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_r   <= MEM_A;
      prim_d_r <= 1'b0;
    end else begin
      prim_d_r <= sw_p;
      // Momentary styles start over from A each time they are entered from a static style
      if (reinit_go || style_static) begin
        base_r <= MEM_A;
      end else if (press_ok) begin
        base_r <= base_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Low-supply handling
  // ----------------------------------------------------------------
  logic low_mute_r;
  logic reinit_r;

  // Deep mode only lets go after the supply has crossed 0.6 V
  wire release_w = low_mute_r & a110 & (~sup_deep | reinit_r);
  assign reinit_go = release_w & (reinit_r | ~a060);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_mute_r <= 1'b0;
      reinit_r   <= 1'b0;
    end else begin
      low_mute_r <= ~a095 | (low_mute_r & ~release_w);
      reinit_r   <= (reinit_r | (low_mute_r & ~a060)) & ~release_w;
    end
  end

  // ----------------------------------------------------------------
  // Power-on audio delay
  // ----------------------------------------------------------------
  logic [3:0]  por_left_r;
  logic [31:0] unit_cnt_r;
  logic [3:0]  por_load;

  assign por_run  = por_left_r != 4'h0;
  assign por_load = (por_cfg > POR_MAX_UNITS) ? POR_MAX_UNITS : por_cfg;
  wire unit_tick  = unit_cnt_r == 32'(UNIT_CYCLES - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_left_r <= POR_RST_UNITS;
      unit_cnt_r <= '0;
    end else if (reinit_go) begin
      por_left_r <= por_load;
      unit_cnt_r <= '0;
    end else if (por_run) begin
      unit_cnt_r <= unit_tick ? 32'h0000_0000 : unit_cnt_r + 32'h1;
      if (unit_tick) begin
        por_left_r <= por_left_r - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory switch fader
  // ----------------------------------------------------------------
  pms_state_t  state_r;
  pms_state_t  state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [2:0]  mem_r;
  logic [2:0]  tgt_r;
  logic        beep_r;
  logic        tone_r;
  logic        ind_r;
  logic        fdown_r;
  logic        aen_r;

  // While audio is off the memory follows silently, no fade needed
  wire audio_off = por_run | low_mute_r;
  wire mem_chg   = mem_r != req_mem;
  wire cnt_done  = cnt_r == 32'h0000_0000;
  wire start_w   = (state_r == ST_IDLE) & ~audio_off &
                   (mem_chg | (tone_r != tone_cfg) | prog_busy);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - 32'h1;
    case (state_r)
      ST_IDLE: begin
        if (start_w) begin
          state_nxt = ST_FADE_OUT;
          cnt_nxt   = 32'(FADE_CYCLES - 1);
        end
      end
      ST_FADE_OUT: begin
        if (cnt_done) begin
          state_nxt = beep_r ? ST_BEEP : ST_SWITCH;
          cnt_nxt   = 32'(BEEP_CYCLES - 1);
        end
      end
      ST_BEEP: begin
        if (cnt_done) begin
          state_nxt = ST_SWITCH;
        end
      end
      ST_SWITCH: begin
        // Programming keeps the fader down until it completes
        if (!prog_busy) begin
          state_nxt = ST_FADE_IN;
          cnt_nxt   = 32'(FADE_CYCLES - 1);
        end
      end
      ST_FADE_IN: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (reinit_go) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      tgt_r   <= MEM_A;
      beep_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (start_w) begin
        tgt_r  <= req_mem;
        beep_r <= mem_chg & beep_en;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_r  <= MEM_A;
      tone_r <= 1'b0;
    end else if (reinit_go) begin
      mem_r <= MEM_A;
    end else if (audio_off && state_r == ST_IDLE) begin
      mem_r  <= req_mem;
      tone_r <= tone_cfg;
    end else if (state_r == ST_SWITCH) begin
      mem_r  <= tgt_r;
      tone_r <= tone_cfg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ind_r   <= 1'b0;
      fdown_r <= 1'b0;
      aen_r   <= 1'b0;
    end else begin
      ind_r   <= state_r == ST_FADE_OUT && state_nxt == ST_BEEP;
      fdown_r <= state_nxt == ST_FADE_OUT || state_nxt == ST_BEEP ||
                 state_nxt == ST_SWITCH;
      aen_r   <= ~audio_off;
    end
  end

  assign memory_sel      = mem_r;
  assign tone_enable     = tone_r;
  assign indicator_start = ind_r;
  assign fader_down      = fdown_r;
  assign audio_enable    = aen_r;

  assign status_w = {21'h0, reinit_r, sw_s, sw_p, tone_r,
                     state_r != ST_IDLE, por_run, low_mute_r, 1'b0, mem_r};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  skip_mem_d_a: assert property (
    @(posedge clk) disable iff (rst)
    press_ok && mode_mom_jump |=> base_r != MEM_D)
    else $error("momentary-jump step landed on memory D");

  jump_to_d_a: assert property (
    @(posedge clk) disable iff (rst)
    mode_mom_jump && sw_s && audio_off && state_r == ST_IDLE && !reinit_go
    |=> memory_sel == MEM_D)
    else $error("secondary high did not select memory D");

  press_ignored_a: assert property (
    @(posedge clk) disable iff (rst)
    mode_mom_jump && sw_s && press_w && !reinit_go |=> $stable(base_r))
    else $error("press acted while secondary switch high");

  restore_mem_a: assert property (
    @(posedge clk) disable iff (rst)
    mode_mom_jump && $fell(sw_s) && audio_off && state_r == ST_IDLE
    && !reinit_go |=> memory_sel == $past(base_r))
    else $error("memory not restored after secondary opened");

  dual_decode_a: assert property (
    @(posedge clk) disable iff (rst)
    mode_static_dual && sw_s && !sw_p && audio_off && state_r == ST_IDLE
    && !reinit_go |=> memory_sel == (valid_w[MEM_C] ? MEM_C : MEM_A))
    else $error("dual static decode gave wrong memory");

  static_jump_a: assert property (
    @(posedge clk) disable iff (rst)
    mode_static_jump && sw_s && audio_off && state_r == ST_IDLE
    && !reinit_go |=> memory_sel == MEM_D)
    else $error("static jump did not hold memory D");

  switch_faded_a: assert property (
    @(posedge clk) disable iff (rst)
    $changed(memory_sel) && !$past(audio_off) && !$past(reinit_go)
    |-> $past(fader_down))
    else $error("memory changed with fader up");

  beep_order_a: assert property (
    @(posedge clk) disable iff (rst)
    indicator_start |-> fader_down ##1 state_r == ST_BEEP)
    else $error("indicator not inside faded interval");

  por_quiet_a: assert property (
    @(posedge clk) disable iff (rst)
    por_run && $past(por_run) |-> !audio_enable)
    else $error("audio enabled during power-on delay");

  por_press_a: assert property (
    @(posedge clk) disable iff (rst)
    press_w && por_run && !reinit_go |=> $stable(base_r))
    else $error("press accepted during power-on delay");

  low_mute_a: assert property (
    @(posedge clk) disable iff (rst)
    !a095 |=> low_mute_r ##1 !audio_enable)
    else $error("audio not muted below 0.95 V");

  deep_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    sup_deep && low_mute_r && !reinit_r && a060 |=> low_mute_r)
    else $error("deep mode released before 0.6 V reset");

endmodule

// File: bench/pms_partner.sv
// Model of the program switches and the supply level comparators
`timescale 1ns/10ps
module pms_partner (
  input  wire logic clk,  // System clock
  output logic      sw_p, // Primary switch pin
  output logic      sw_s, // Secondary switch pin
  output logic      a095, // Supply over 0.95 V
  output logic      a110, // Supply over 1.1 V
  output logic      a060  // Supply over 0.6 V
);
  // ----------------------------------------------------------------
  // Switches and supply
  // ----------------------------------------------------------------
  int mv = 1300;
  // Ideal comparators, supply held in millivolts
  assign a095 = (mv > 950);
  assign a110 = (mv > 1100);
  assign a060 = (mv > 600);
  initial begin
    sw_p = 1'b0;
    sw_s = 1'b0;
  end
  task set_sw(input logic p, input logic s);
    @(posedge clk);
    sw_p <= p;
    sw_s <= s;
  endtask
  // Held several cycles so the synchroniser cannot miss the press
  task press();
    set_sw(1'b1, sw_s);
    repeat (4) @(posedge clk);
    sw_p <= 1'b0;
  endtask
  task set_mv(input int v);
    @(posedge clk);
    mv <= v;
  endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the program memory selector
`timescale 1ns/10ps
module tb_top;
  import pms_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [2:0] MEM_E = 3'h4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sw_p, sw_s, a095, a110, a060;
  logic [2:0]  memory_sel, prev_mem;
  logic        audio_enable, fader_down, indicator_start, tone_enable;
  logic        prev_fd;
  logic [31:0] rd;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          beeps = 0;
  int          b0;
  always #10 clk = ~clk;
  pms_partner i_partner (.clk(clk), .sw_p(sw_p), .sw_s(sw_s),
                         .a095(a095), .a110(a110), .a060(a060));
  pms_selector #(.FADE_CYCLES(8), .BEEP_CYCLES(6), .UNIT_CYCLES(20)) i_dut (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .primary_select_switch(sw_p), .secondary_select_switch(sw_s),
    .supply_above_095(a095), .supply_above_110(a110),
    .supply_above_060(a060), .memory_sel(memory_sel),
    .audio_enable(audio_enable), .fader_down(fader_down),
    .indicator_start(indicator_start), .tone_enable(tone_enable));
  // Watchdog, beep count, and no audible memory change outside a fade
  always @(posedge clk) begin
    cyc++;
    if (indicator_start === 1'b1) beeps++;
    if (audio_enable === 1'b1 && memory_sel !== prev_mem &&
        fader_down !== 1'b1 && prev_fd !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: memory changed with fader up", $time);
    end
    prev_mem = memory_sel;
    prev_fd = fader_down;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task report_and_stop();
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task bus_wr(input logic [3:0] a, input logic [31:0] d,
              input logic [3:0] b = 4'hF);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task bus_rd(input logic [3:0] a);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic wait_bit(ref logic s, input logic v);
    repeat (200) begin
      @(posedge clk);
      if (s === v) break;
    end
  endtask
  task wait_mem(input logic [2:0] e);
    repeat (300) begin
      @(posedge clk);
      if (memory_sel === e && fader_down === 1'b0) break;
    end
    chk(32'(memory_sel), 32'(e), "memory");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_por();
    i_partner.press();
    chk(32'(audio_enable), 32'h0, "audio in delay");
    wait_bit(audio_enable, 1'b1);
    chk(32'(audio_enable), 32'h1, "audio after delay");
    chk(32'(memory_sel), 32'(MEM_A), "press in delay");
  endtask
  task t_regs();
    bus_rd(ADDR_CTRL);
    chk(rd, CTRL_RST, "ctrl reset");
    bus_rd(ADDR_VALID);
    chk(rd, VALID_RST, "valid reset");
    bus_rd(ADDR_STATUS);
    chk(rd, 32'h0, "status idle");
    bus_wr(ADDR_CTRL, 32'hFFFF_0300, 4'h2);
    bus_rd(ADDR_CTRL);
    chk(rd, 32'h0000_0304, "byte lane write");
    bus_wr(ADDR_CTRL, CTRL_RST);
    bus_rd(4'hC);
    chk(rd, 32'h0, "unmapped read");
  endtask
  task t_mom();
    bus_wr(ADDR_VALID, 32'h7);
    b0 = beeps;
    i_partner.press();
    wait_mem(MEM_B);
    i_partner.press();
    wait_mem(MEM_C);
    i_partner.press();
    wait_mem(MEM_A);
    chk(32'(beeps - b0), 32'h3, "beeps");
  endtask
  task t_mjump();
    bus_wr(ADDR_VALID, 32'h3F);
    bus_wr(ADDR_CTRL, 32'h206);
    i_partner.press();
    wait_mem(MEM_B);
    i_partner.press();
    wait_mem(MEM_C);
    i_partner.press();
    wait_mem(MEM_E);
    i_partner.set_sw(1'b0, 1'b1);
    wait_mem(MEM_D);
    b0 = beeps;
    i_partner.press();
    repeat (40) @(posedge clk);
    chk(32'(memory_sel), 32'(MEM_D), "press ignored");
    chk(32'(beeps - b0), 32'h0, "no beep");
    i_partner.set_sw(1'b0, 1'b0);
    wait_mem(MEM_E);
  endtask
  task t_static(input logic [31:0] ctl, input logic [2:0] e [4]);
    bus_wr(ADDR_VALID, 32'hF);
    bus_wr(ADDR_CTRL, ctl);
    for (int i = 0; i < 4; i++) begin
      i_partner.set_sw(i[0], i[1]);
      wait_mem(e[i]);
    end
    b0 = beeps;
    i_partner.set_sw(1'b0, 1'b1);
    wait_mem(e[2]);
  endtask
  task t_supply(input logic [31:0] ctl, input logic deep);
    bus_wr(ADDR_CTRL, ctl);
    i_partner.press();
    wait_mem(MEM_B);
    i_partner.set_mv(900);
    wait_bit(audio_enable, 1'b0);
    chk(32'(audio_enable), 32'h0, "mute");
    i_partner.set_mv(1000);
    repeat (20) @(posedge clk);
    chk(32'(audio_enable), 32'h0, "still muted");
    i_partner.set_mv(1200);
    repeat (30) @(posedge clk);
    chk(32'(audio_enable), {31'h0, !deep}, "unmute");
    i_partner.set_mv(500);
    // A real dip lasts far longer than the synchroniser delay
    repeat (10) @(posedge clk);
    i_partner.set_mv(1200);
    wait_bit(audio_enable, 1'b1);
    chk(32'(audio_enable), 32'h1, "resume");
    chk(32'(memory_sel), 32'(MEM_A), "reinit memory");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_por();
    t_regs();
    t_mom();
    t_mjump();
    t_static(32'h205, '{MEM_A, MEM_B, MEM_C, MEM_D});
    bus_wr(ADDR_VALID, 32'hB);
    wait_mem(MEM_A);
    t_static(32'h207, '{MEM_A, MEM_B, MEM_D, MEM_D});
    repeat (40) @(posedge clk);
    chk(32'(beeps - b0), 32'h0, "primary ignored");
    i_partner.set_sw(1'b0, 1'b0);
    wait_mem(MEM_A);
    bus_wr(ADDR_CTRL, 32'h245);
    wait_bit(fader_down, 1'b1);
    chk(32'(fader_down), 32'h1, "tone fade");
    wait_bit(fader_down, 1'b0);
    chk(32'(tone_enable), 32'h1, "tone on");
    bus_wr(ADDR_CTRL, 32'h2C5);
    wait_bit(fader_down, 1'b1);
    repeat (40) @(posedge clk);
    chk(32'(fader_down), 32'h1, "programming hold");
    t_supply(32'h204, 1'b0);
    t_supply(32'h214, 1'b1);
    t_supply(32'h224, 1'b0);
    report_and_stop();
  end
endmodule
